/* rtl/async_write_data_delay_timing.sv */
// Purpose: Drives the multiplexed address/data bus during external writes
// Assumes: Phase lengths arrive as cycle counts; all inputs on clk
// Notes: Every timing point falls on a whole bus clock edge
// How it works
// - Edge select and clock ratio steer data timing
// - Async half-cycle release becomes one full period
// - Async drivers switch on without any delay
// - Drive filler data until delayed valid data
// - Async half-cycle valid-data delay becomes one full period
// - Ratio 00 data at once, else after first if delayed
// - Drivers on at first command cycle regardless
// - Release after last hold, plus one if delayed
// - All timing counted in whole bus clocks
`timescale 1ns/1ps
module async_write_data_delay_timing
    import wdata_timing_pkg::*;
#(
    parameter int LEN_W = wdata_timing_pkg::LEN_WIDTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic region_async,
    input wire logic edge_select_delay,
    input wire logic [1:0] bus_clock_ratio,
    input wire logic [LEN_W-1:0] cmd_cycles,
    input wire logic [LEN_W-1:0] hold_cycles,
    input wire logic [wdata_timing_pkg::BUS_WIDTH-1:0] write_data,
    output logic [wdata_timing_pkg::BUS_WIDTH-1:0] ext_addr_data_bus_out,
    output logic ext_addr_data_bus_oe,
    output logic data_valid,
    output logic busy
);
    import wdata_timing_pkg::*;

    // ****************************************************************
    // Settings decode
    // ****************************************************************
    // Delay requested by software for this access
    wire delay_on = edge_select_delay;
    // Direct ratio: valid data from the start of the first command cycle
    wire ratio_direct = (bus_clock_ratio == RATIO_DIRECT);
    // Valid data is held back one cycle only for divided ratios with delay
    wire next_late_data = delay_on && !ratio_direct;
    // Release extended by one full period when delayed
    wire next_late_release = delay_on;

    // Latched settings of the running access
    logic late_data;
    logic late_release;
    logic is_async;
    logic [LEN_W-1:0] hold_len;
    logic [BUS_WIDTH-1:0] data_hold;
    phase_t state;
    phase_t next_state;

    // Phase counter interface
    logic cnt_load;
    logic [LEN_W-1:0] cnt_len;
    logic cnt_last;

    // High in the first command cycle of an access
    logic first_cycle;
    // Filler shown while valid data is still held back
    wire show_fill = (state == st_cmd) && late_data && first_cycle;

    // ****************************************************************
    // Phase sequencing
    // ****************************************************************
    wire access_start = (state == st_idle) && start;
    wire has_hold = (hold_len != '0);

    // Next state and counter load, counted in bus clocks
    always_comb
    begin
        next_state = state;
        cnt_load = 1'b0;
        cnt_len = cmd_cycles;
        case (state)
            st_idle:
            begin
                if (start)
                begin
                    next_state = st_cmd;
                    cnt_load = 1'b1;
                end
            end
            st_cmd:
            begin
                if (cnt_last)
                begin
                    if (has_hold)
                    begin
                        next_state = st_hold;
                        cnt_load = 1'b1;
                        cnt_len = hold_len;
                    end
                    else if (late_release)
                        // Without a hold phase the last command cycle is the reference
                        next_state = is_async ? st_tail : st_sync_tail;
                    else
                        next_state = st_idle;
                end
            end
            st_hold:
            begin
                if (cnt_last)
                    next_state = late_release
                        ? (is_async ? st_tail : st_sync_tail) : st_idle;
            end
            st_tail:
                next_state = st_idle;
            st_sync_tail:
                next_state = st_idle;
            default:
                next_state = st_idle;
        endcase
    end

    phase_counter #(
        .WIDTH(LEN_W)
    ) u_phase (
        .clk(clk),
        .reset(reset),
        .load(cnt_load),
        .length(cnt_len),
        .last(cnt_last)
    );

    // ****************************************************************
    // State and settings capture
    // ****************************************************************
    // Settings are frozen at access start so mid-access writes do no harm
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= st_idle;
            late_data <= 1'b0;
            late_release <= 1'b0;
            is_async <= 1'b0;
            hold_len <= '0;
            data_hold <= BUS_RESET;
            first_cycle <= 1'b0;
        end
        else
        begin
            state <= next_state;
            first_cycle <= access_start;
            if (access_start)
            begin
                // Sync regions keep their programmed behaviour, same timing here
                late_data <= next_late_data;
                late_release <= next_late_release;
                is_async <= region_async;
                hold_len <= hold_cycles;
                data_hold <= write_data;
            end
        end
    end

    // ****************************************************************
    // Bus drive
    // ****************************************************************
    // Drivers enable from the first command cycle, never delayed
    wire next_oe = (next_state != st_idle);
    wire next_valid = next_oe && !(access_start && next_late_data);
    // Filler during the held-back first cycle, real data afterwards
    wire [BUS_WIDTH-1:0] next_bus = !next_oe ? BUS_RESET
        : (next_valid ? (access_start ? write_data : data_hold) : FILL_DATA);

    // Registered outputs
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ext_addr_data_bus_out <= BUS_RESET;
            ext_addr_data_bus_oe <= 1'b0;
            data_valid <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            ext_addr_data_bus_out <= next_bus;
            ext_addr_data_bus_oe <= next_oe;
            data_valid <= next_valid;
            busy <= next_oe;
        end
    end
endmodule

/* shared/wdata_timing_pkg.sv */
// Purpose: Shared constants and types for the write-data drive timing block
// Assumes: One bus clock; phase lengths come in as cycle counts from outside
// Notes: Ratio codes are the two-bit clock ratio field encodings
package wdata_timing_pkg;
    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int BUS_WIDTH = 32;
    localparam int LEN_WIDTH = 4;
    // ****************************************************************
    // Clock ratio field codes
    // ****************************************************************
    localparam logic [1:0] RATIO_DIRECT = 2'h0;
    // ****************************************************************
    // Reset and filler values
    // ****************************************************************
    localparam logic [31:0] BUS_RESET = 32'h0;
    localparam logic [31:0] FILL_DATA = 32'hdeadbeef;
    // Access phase states
    typedef enum logic [2:0] {st_idle, st_cmd, st_hold, st_tail, st_sync_tail} phase_t;
endpackage

/* rtl/phase_counter.sv */
// Purpose: Down counter that marks the last cycle of a programmed phase
// Notes: A length of zero is treated as one cycle
`timescale 1ns/1ps
module phase_counter #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [WIDTH-1:0] length,
    output logic last
);
    // Remaining cycles of the phase after this one
    logic [WIDTH-1:0] remain;
    assign last = (remain == '0);
    // ****************************************************************
    // Count
    // ****************************************************************
    // Load at phase start, otherwise count down to zero
    always_ff @(posedge clk)
    begin
        if (reset)
            remain <= '0;
        else if (load)
            remain <= (length == '0) ? '0 : WIDTH'(length - 1'b1);
        else if (remain != '0)
            remain <= WIDTH'(remain - 1'b1);
    end
endmodule

/* sim/wdata_timing_props.sv */
// Purpose: Timing checks on the write-data bus outputs
// Assumes: One clock, sync reset
// Notes: Helper logic counts the drive window
`timescale 1ns/1ps
module wdata_timing_props
    import wdata_timing_pkg::*;
#(
    parameter int LEN_W = LEN_WIDTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic region_async,
    input wire logic edge_select_delay,
    input wire logic [1:0] bus_clock_ratio,
    input wire logic [LEN_W-1:0] cmd_cycles,
    input wire logic [LEN_W-1:0] hold_cycles,
    input wire logic [BUS_WIDTH-1:0] write_data,
    input wire logic [BUS_WIDTH-1:0] ext_addr_data_bus_out,
    input wire logic ext_addr_data_bus_oe,
    input wire logic data_valid,
    input wire logic busy
);
wire take = start && !busy; // Accepted request
wire late = edge_select_delay && bus_clock_ratio != RATIO_DIRECT; // Delayed valid data
logic [BUS_WIDTH-1:0] word; // Word taken at accept
logic [7:0] want; // Expected drive length
logic [7:0] seen; // Cycles driven so far
// Capture what the access promised, count what it delivered
always_ff @(posedge clk)
begin
    if (take)
    begin
        word <= write_data;
        want <= 8'(cmd_cycles == 0 ? 1 : cmd_cycles) + 8'(hold_cycles) + 8'(edge_select_delay);
    end
    seen <= (ext_addr_data_bus_oe && !reset) ? seen + 8'h1 : 8'h0;
end
default clocking cb @(posedge clk); endclocking
default disable iff (reset);
drive_on_a: assert property (take |=> ext_addr_data_bus_oe)
    else $error("bus not driven after accept");
valid_now_a: assert property (take && !late |=> data_valid && ext_addr_data_bus_out == word)
    else $error("valid data not at first cycle");
valid_late_a: assert property (take && late |=> !data_valid && ext_addr_data_bus_out == FILL_DATA
    ##1 data_valid && ext_addr_data_bus_out == word)
    else $error("delayed data phase wrong");
valid_word_a: assert property (data_valid |-> ext_addr_data_bus_oe && ext_addr_data_bus_out == word)
    else $error("valid data not the accepted word");
release_len_a: assert property ($fell(ext_addr_data_bus_oe) |-> seen == want)
    else $error("bus released at wrong cycle");
idle_zero_a: assert property (!ext_addr_data_bus_oe |-> ext_addr_data_bus_out == 0 && !data_valid)
    else $error("bus value while released");
rise_cause_a: assert property ($rose(ext_addr_data_bus_oe) |-> $past(take))
    else $error("drive without accept");
busy_oe_a: assert property (busy == ext_addr_data_bus_oe)
    else $error("busy differs from drive");
endmodule
bind async_write_data_delay_timing wdata_timing_props #(.LEN_W(LEN_W)) u_props (.clk(clk),
    .reset(reset), .start(start), .region_async(region_async), .edge_select_delay(edge_select_delay),
    .bus_clock_ratio(bus_clock_ratio), .cmd_cycles(cmd_cycles), .hold_cycles(hold_cycles),
    .write_data(write_data), .ext_addr_data_bus_out(ext_addr_data_bus_out),
    .ext_addr_data_bus_oe(ext_addr_data_bus_oe), .data_valid(data_valid), .busy(busy));

/* sim/ext_mem_model.sv */
// Purpose: Far-side memory keeping the last valid written word
// Assumes: No wait states
// Notes: Filler data is never stored
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic clk,
    input wire logic [31:0] bus,
    input wire logic oe,
    input wire logic valid,
    output logic [31:0] stored
);
initial stored = 32'h0;
// Store only a word both driven and valid
always @(posedge clk)
begin
    if (oe && valid)
    begin
        stored <= bus;
    end
end
endmodule

/* sim/test_async_write_data_delay_timing.sv */
// Purpose: Drives write accesses and checks bus timing
// Assumes: Inputs change at falling edges
// Notes: Length checks count driven cycles at falling edges
`timescale 1ns/1ps
module test_async_write_data_delay_timing;
import wdata_timing_pkg::*;
logic clk = 1'b0, reset = 1'b1, start = 1'b0, region_async = 1'b1, edge_select_delay = 1'b0;
logic [1:0] bus_clock_ratio = 2'h0;
logic [3:0] cmd_cycles = 4'h0, hold_cycles = 4'h0;
logic [31:0] write_data = 32'h0;
wire [31:0] bus, stored;
wire oe, valid, busy;
int failures = 0, checks_done = 0, cycles = 0;
async_write_data_delay_timing u_dut (.clk(clk), .reset(reset), .start(start),
    .region_async(region_async), .edge_select_delay(edge_select_delay),
    .bus_clock_ratio(bus_clock_ratio), .cmd_cycles(cmd_cycles), .hold_cycles(hold_cycles),
    .write_data(write_data), .ext_addr_data_bus_out(bus), .ext_addr_data_bus_oe(oe),
    .data_valid(valid), .busy(busy));
ext_mem_model u_mem (.clk(clk), .bus(bus), .oe(oe), .valid(valid), .stored(stored));
initial forever #4 clk = ~clk;
task automatic check(input string what, input logic [31:0] expv, got);
    checks_done++;
    if (got !== expv)
    begin
        failures++;
        $display("FAIL %s expected %h seen %h", what, expv, got);
    end
endtask
// Request at one falling edge, then follow the drive window
task automatic access(input logic d, input logic [1:0] r, input logic [3:0] c, h,
    input logic [31:0] w, input logic hit);
    int n;
    @(negedge clk);
    edge_select_delay = d;
    bus_clock_ratio = r;
    cmd_cycles = c;
    hold_cycles = h;
    write_data = w;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    write_data = ~w;
    n = 0;
    while (oe === 1'b1 && n < 40)
    begin
        if (n == 0) check("first word", (d && r != 0) ? FILL_DATA : w, bus);
        n++;
        if (n == 1 && hit == 0) start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    end
    check("drive length", 32'((c == 0 ? 1 : c) + h + d), 32'(n));
    check("stored word", w, stored);
    check("idle bus", 32'h0, {bus[31:1], bus[0] | oe});
endtask
task automatic t_ratio_table;
    for (int k = 0; k < 8; k++) access(k[2], k[1:0], 4'h2, 4'h1, 32'h1000_0000 + k, 1);
endtask
task automatic t_no_hold;
    access(1, 2'h1, 4'h0, 4'h0, 32'ha5a5_0f0f, 1);
    access(0, 2'h0, 4'hf, 4'hf, 32'h0f0f_a5a5, 1);
endtask
// Second start lands while busy and must be dropped
task automatic t_refused;
    access(0, 2'h3, 4'h3, 4'h0, 32'h5a5a_0001, 1'b0);
endtask
task automatic t_sync;
    region_async = 1'b0;
    access(1, 2'h2, 4'h1, 4'h1, 32'hc3c3_3c3c, 1);
    region_async = 1'b1;
endtask
task automatic end_of_test;
    if (failures == 0 && checks_done > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
// Cut a hang short
always @(posedge clk)
begin
    cycles++;
    if (cycles == 3000)
    begin
        failures++;
        end_of_test();
    end
end
initial
begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_ratio_table();
    t_no_hold();
    t_refused();
    t_sync();
    end_of_test();
end
endmodule
